// [loop_break_params.svh]
// constants for the loop break alarm monitor: offsets, fields, resets, timing
`ifndef LOOP_BREAK_PARAMS_SVH
`define LOOP_BREAK_PARAMS_SVH

// ==========================================
// register byte offsets
`define REG_CTRL        8'h00
`define REG_CHECK_TIME  8'h04
`define REG_THRESHOLD   8'h08
`define REG_REDUCTION   8'h0c
`define REG_STATUS      8'h10
`define REG_IRQ_STATUS  8'h14
`define REG_IRQ_CLEAR   8'h18
`define REG_IRQ_ENABLE  8'h1c

// ==========================================
// fields and codes
`define CTRL_TYPE_MSB    3
`define CTRL_TYPE_LSB    0
`define LOOP_BREAK_CODE  4'hc
`define SETTING_MAX      14'h270f
`define THRESHOLD_MIN    14'h0001
`define EV_ALARM_ON      0
`define EV_ALARM_OFF     1
`define EV_REJECT        2
`define EV_COUNT         3

// ==========================================
// reset values
`define CHECK_TIME_RST   14'h0000
`define THRESHOLD_RST    14'h0050
`define REDUCTION_RST    14'h001e
`define TYPE_RST         4'h0

// ==========================================
// timing
`define SECOND_NS        1000000000
`define CLOCK_NS         100
`define TICK_CYCLES      (`SECOND_NS / `CLOCK_NS)

`endif

// [loop_break_pkg.sv]
// types shared by the loop break alarm monitor
package loop_break_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WATCH = 3'b010,
    ST_ALARM = 3'b100
  } detect_state_type;

  typedef logic [13:0] setting_type;
  typedef logic [2:0]  event_vec_type;

endpackage

// [event_bank_if.sv]
// carrier between the monitor and its sticky event bank
`timescale 1ns/1ps
`default_nettype none

interface event_bank_if;
  import loop_break_pkg::*;
  event_vec_type setEvents;
  event_vec_type clearEvents;
  event_vec_type enableMask;
  event_vec_type status;
  logic          irq;

  modport bank (input setEvents, input clearEvents, input enableMask,
                output status, output irq);
  modport user (output setEvents, output clearEvents, output enableMask,
                input status, input irq);
endinterface

`default_nettype wire

// [event_bank.sv]
// sticky event status with write-one-to-clear and masked level interrupt
`timescale 1ns/1ps
`default_nettype none

module event_bank (
  input  wire logic   clock,
  input  wire logic   rst,
  event_bank_if.bank  evt
);
  import loop_break_pkg::*;

  event_vec_type status_r;

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r & ~evt.clearEvents) | evt.setEvents;
    end
  end

  assign evt.status = status_r;
  assign evt.irq    = |(status_r & evt.enableMask);

endmodule // event_bank

`default_nettype wire

// [loop_break_alarm_monitor.sv]
// loop break alarm monitor: apb registers, one-second tick, detection state machine
//
// Notes on behaviour
// - alarm when deviation above threshold fails to shrink by reduction within period.
// - alarm stays off while deviation shrinks by at least the reduction.
// - deviation within threshold: no detection, alarm held off.
// - raised alarm clears when deviation shrinks by reduction within a period.
// - shrinking by less than the reduction within a period raises the alarm.
// - check period setting in seconds, 0 to 9999, reset value 0.
// - deviation threshold setting 0.1 to 999.9, reset value 8.0.
// - required reduction setting 0.0 to 999.9, reset value 3.0.
// - detection runs only when the alarm type field holds code 12.
// - setting writes accepted only while stopped; rejected while running.
// - settings follow sensor decimals; zero decimals treated as one decimal.
// - autotune end loads check period, except under heating and cooling control.
// - no detection while the target value is ramping.
// - no detection during autotuning, manual operation or stop.
//
// The APB register port and the register offsets were left to the implementer.
`include "loop_break_params.svh"
`timescale 1ns/1ps
`default_nettype none

module loop_break_alarm_monitor #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic                        clock,
  input  wire logic                        rst,
  // apb slave
  input  wire logic [7:0]                  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // control loop side
  input  wire logic signed [15:0]          deviation,
  input  wire logic [1:0]                  sensorDecimals,
  input  wire logic                        running,
  input  wire logic                        ramping,
  input  wire logic                        autotuning,
  input  wire logic                        manualMode,
  input  wire logic                        heatCool,
  input  wire logic                        tuneDone,
  input  wire loop_break_pkg::setting_type tuneCheckPeriod,
  // results
  output logic                             loopBreakAlarm,
  output logic                             irq
);
  import loop_break_pkg::*;

  // ==========================================
  // apb access decode
  logic        accessPhase;
  logic        writeAccess;
  logic        hitCtrl;
  logic        hitCheck;
  logic        hitThreshold;
  logic        hitReduction;
  logic        hitStatus;
  logic        hitIrqStatus;
  logic        hitIrqClear;
  logic        hitIrqEnable;
  logic        hitSetting;
  logic        unmapped;
  logic        valueBad;
  logic        rejectWrite;
  setting_type wrSetting;

  assign accessPhase  = psel & penable;
  assign writeAccess  = accessPhase & pwrite;
  assign hitCtrl      = (paddr == `REG_CTRL);
  assign hitCheck     = (paddr == `REG_CHECK_TIME);
  assign hitThreshold = (paddr == `REG_THRESHOLD);
  assign hitReduction = (paddr == `REG_REDUCTION);
  assign hitStatus    = (paddr == `REG_STATUS);
  assign hitIrqStatus = (paddr == `REG_IRQ_STATUS);
  assign hitIrqClear  = (paddr == `REG_IRQ_CLEAR);
  assign hitIrqEnable = (paddr == `REG_IRQ_ENABLE);
  assign hitSetting   = hitCheck | hitThreshold | hitReduction;
  assign unmapped     = ~(hitCtrl | hitSetting | hitStatus | hitIrqStatus
                          | hitIrqClear | hitIrqEnable);
  assign wrSetting    = pwdata[13:0];

  // out-of-range values are refused whole rather than clipped
  assign valueBad = (pwdata[31:14] != 18'h00000)
                  | (wrSetting > `SETTING_MAX)
                  | (hitThreshold & (wrSetting < `THRESHOLD_MIN));
  assign rejectWrite = writeAccess & hitSetting & (running | valueBad);

  // zero wait states: every access finishes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = accessPhase & (unmapped | rejectWrite);

  // ==========================================
  // configuration registers
  logic [3:0]    alarmType_r;
  setting_type   checkPeriod_r;
  setting_type   threshold_r;
  setting_type   reduction_r;
  event_vec_type irqEnable_r;
  logic          tuneLoad;
  setting_type   tuneValue;

  assign tuneLoad  = tuneDone & ~heatCool;
  assign tuneValue = (tuneCheckPeriod > `SETTING_MAX) ? `SETTING_MAX : tuneCheckPeriod;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarmType_r <= `TYPE_RST;
      irqEnable_r <= '0;
    end else if (writeAccess & hitCtrl) begin
      alarmType_r <= pwdata[`CTRL_TYPE_MSB:`CTRL_TYPE_LSB];
    end else if (writeAccess & hitIrqEnable) begin
      irqEnable_r <= pwdata[`EV_COUNT-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      checkPeriod_r <= `CHECK_TIME_RST;
    end else if (tuneLoad) begin
      checkPeriod_r <= tuneValue;
    end else if (writeAccess & hitCheck & ~rejectWrite) begin
      checkPeriod_r <= wrSetting;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      threshold_r <= `THRESHOLD_RST;
      reduction_r <= `REDUCTION_RST;
    end else if (writeAccess & ~rejectWrite & hitThreshold) begin
      threshold_r <= wrSetting;
    end else if (writeAccess & ~rejectWrite & hitReduction) begin
      reduction_r <= wrSetting;
    end
  end

  // ==========================================
  // one-second tick
  logic [23:0] tickCount_r;
  logic        secondTick;

  assign secondTick = (tickCount_r == 24'(TICK_CYCLES - 1));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tickCount_r <= '0;
    end else if (secondTick) begin
      tickCount_r <= '0;
    end else begin
      tickCount_r <= tickCount_r + 24'h000001;
    end
  end

  // ==========================================
  // deviation scaling to setting units: tenths when the sensor has no decimals or one
  logic signed [19:0] devExt;
  logic signed [19:0] devScaled;
  logic        [19:0] devMag;
  logic        [19:0] thresholdWide;
  logic        [19:0] reductionWide;

  assign devExt        = {{4{deviation[15]}}, deviation};
  // sensor with no decimals: settings still hold one decimal, so lift the input
  assign devScaled     = (sensorDecimals == 2'h0) ? ((devExt <<< 3) + (devExt <<< 1))
                                                  : devExt;
  assign devMag        = devScaled[19] ? 20'(-devScaled) : 20'(devScaled);
  assign thresholdWide = {6'h00, threshold_r};
  assign reductionWide = {6'h00, reduction_r};

  // ==========================================
  // detection state machine
  detect_state_type state_r;
  detect_state_type state_nxt;
  logic [13:0]      periodCount_r;
  logic [19:0]      startMag_r;
  logic             typeMatch;
  logic             allowed;
  logic             outside;
  logic             periodEnd;
  logic             shrunkEnough;
  logic             capture;

  assign typeMatch = (alarmType_r == `LOOP_BREAK_CODE);
  assign allowed   = typeMatch & running & ~ramping
                   & ~autotuning & ~manualMode
                   & (checkPeriod_r != 14'h0000);
  assign outside   = devMag > thresholdWide;
  assign periodEnd = secondTick & ((periodCount_r + 14'h0001) >= checkPeriod_r);
  assign shrunkEnough = (startMag_r >= devMag)
                      & ((startMag_r - devMag) >= reductionWide);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (allowed & outside) begin
          state_nxt = ST_WATCH;
        end
      end
      ST_WATCH: begin
        if (~allowed | ~outside) begin
          state_nxt = ST_IDLE;
        end else if (periodEnd & ~shrunkEnough) begin
          state_nxt = ST_ALARM;
        end
      end
      ST_ALARM: begin
        if (~allowed | ~outside) begin
          state_nxt = ST_IDLE;
        end else if (periodEnd & shrunkEnough) begin
          state_nxt = ST_WATCH;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // a new period starts on entry from idle and at every expiry
  assign capture = ((state_r == ST_IDLE) & (state_nxt == ST_WATCH))
                 | ((state_r != ST_IDLE) & periodEnd);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      periodCount_r <= '0;
      startMag_r    <= '0;
    end else if (state_nxt == ST_IDLE) begin
      periodCount_r <= '0;
    end else if (capture) begin
      periodCount_r <= '0;
      startMag_r    <= devMag;
    end else if (secondTick) begin
      periodCount_r <= periodCount_r + 14'h0001;
    end
  end

  // ==========================================
  // alarm output and events
  logic          alarm_r;
  event_vec_type eventSet;
  event_vec_type eventClear;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarm_r <= 1'b0;
    end else begin
      alarm_r <= (state_nxt == ST_ALARM);
    end
  end

  assign loopBreakAlarm = alarm_r;

  always_comb begin
    eventSet               = '0;
    eventSet[`EV_ALARM_ON]  = (state_nxt == ST_ALARM) & ~alarm_r;
    eventSet[`EV_ALARM_OFF] = (state_nxt != ST_ALARM) & alarm_r;
    eventSet[`EV_REJECT]    = rejectWrite;
  end

  assign eventClear = (writeAccess & hitIrqClear) ? pwdata[`EV_COUNT-1:0] : '0;

  event_bank_if evt ();

  assign evt.setEvents   = eventSet;
  assign evt.clearEvents = eventClear;
  assign evt.enableMask  = irqEnable_r;

  event_bank u_event_bank (
    .clock (clock),
    .rst   (rst),
    .evt   (evt)
  );

  assign irq = evt.irq;

  // ==========================================
  // read data
  logic [31:0] statusWord;
  logic [31:0] readMux;
  logic [31:0] prdata_r;

  assign statusWord = {2'h0, periodCount_r, 13'h0000, state_r == ST_ALARM,
                       state_r != ST_IDLE, allowed};

  assign readMux = (~psel | pwrite) ? 32'h00000000 :
                   hitCtrl          ? {28'h0000000, alarmType_r} :
                   hitCheck         ? {18'h00000, checkPeriod_r} :
                   hitThreshold     ? {18'h00000, threshold_r} :
                   hitReduction     ? {18'h00000, reduction_r} :
                   hitStatus        ? statusWord :
                   hitIrqStatus     ? {29'h0000000, evt.status} :
                   hitIrqEnable     ? {29'h0000000, irqEnable_r} :
                                      32'h00000000;

  // taken in the setup cycle, so the access cycle shows a flopped word with no wait state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_r <= 32'h00000000;
    end else if (psel & ~penable) begin
      prdata_r <= readMux;
    end
  end

  assign prdata = prdata_r;

endmodule // loop_break_alarm_monitor

`default_nettype wire

// [loop_break_chk.sv]
// port-level assertion checker for the loop break alarm monitor
`timescale 1ns/1ps
`default_nettype none

module loop_break_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        running,
  input wire logic        ramping,
  input wire logic        autotuning,
  input wire logic        manualMode,
  input wire logic        loopBreakAlarm
);
  // ==========================================
  // bus and alarm relations
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // three cycles of hold leave room for the registered alarm to drop
  chk_ramp_quiet: assert property (ramping [*3] |-> !loopBreakAlarm)
    else $error("alarm during ramping");
  chk_tune_quiet: assert property (autotuning [*3] |-> !loopBreakAlarm)
    else $error("alarm during autotuning");
  chk_manual_quiet: assert property (manualMode [*3] |-> !loopBreakAlarm)
    else $error("alarm during manual operation");
  chk_stop_quiet: assert property (!running [*3] |-> !loopBreakAlarm)
    else $error("alarm while stopped");
  chk_rise_cause: assert property ($rose(loopBreakAlarm) |->
    $past(running) && !$past(ramping))
    else $error("alarm rose without detection allowed");
  chk_reject_running: assert property (psel && penable && pwrite && running &&
    paddr inside {8'h04, 8'h08, 8'h0c} |-> pslverr)
    else $error("setting write accepted while running");
  chk_unmapped_err: assert property (psel && penable && paddr > 8'h1c |->
    pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_ready_high: assert property (psel |-> pready && (penable || !pslverr))
    else $error("bus answer malformed");
  cover property ($rose(loopBreakAlarm));
  cover property ($fell(loopBreakAlarm));
  cover property (psel && penable && pslverr);
endmodule // loop_break_chk

bind loop_break_alarm_monitor loop_break_chk loop_break_chk_i (
  .clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .running(running), .ramping(ramping),
  .autotuning(autotuning), .manualMode(manualMode), .loopBreakAlarm(loopBreakAlarm)
);

`default_nettype wire

// [tb_top.sv]
// self-checking bench for the loop break alarm monitor
`timescale 1ns/1ps
`default_nettype none
`include "loop_break_params.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end

module tb_top;
  import loop_break_pkg::*;
  localparam int TICK = 4;
  localparam int PER  = 2;
  localparam int RED  = 30;
  logic               clock = 1'b0;
  logic               rst, psel, penable, pwrite, pready, pslverr, er, neg;
  logic               running, ramping, autotuning, manualMode, heatCool, tuneDone;
  logic               loopBreakAlarm, irq;
  logic [7:0]         paddr, addr;
  logic [31:0]        pwdata, prdata, rd, seed;
  logic signed [15:0] deviation;
  logic [1:0]         sensorDecimals;
  setting_type        tuneCheckPeriod;
  int                 error_cnt, checks_done, cyc, mag, val;
  int                 model [3];

  loop_break_alarm_monitor #(.TICK_CYCLES(TICK)) loop_break_alarm_monitor_i (
    .clock(clock), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .deviation(deviation), .sensorDecimals(sensorDecimals), .running(running),
    .ramping(ramping), .autotuning(autotuning), .manualMode(manualMode),
    .heatCool(heatCool), .tuneDone(tuneDone), .tuneCheckPeriod(tuneCheckPeriod),
    .loopBreakAlarm(loopBreakAlarm), .irq(irq)
  );

  always #50 clock = ~clock;

  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic refused(input logic [7:0] a, input int v, input logic run);
    return run || v > 9999 || (a == `REG_THRESHOLD && v == 0);
  endfunction
  // the shortest full period is PER ticks, so this is the worst-case reduction
  function automatic logic exp_alarm(input int step);
    return step * PER * TICK < RED;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // pready ends this wait; only the bench timeout bounds it
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run_dev(input int step, input int n);
    repeat (n) begin
      @(posedge clock);
      deviation <= 16'(neg ? -mag : mag);
      mag = mag - step;
    end
    @(posedge clock);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    if (++cyc > 8000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    {psel, penable, pwrite, running, ramping, autotuning, manualMode, heatCool} = '0;
    {rst, tuneDone, neg, paddr, pwdata, deviation, tuneCheckPeriod} = '0;
    rst = 1'b1;
    sensorDecimals = 2'h1;
    seed = 32'h0000c0a3;
    model = '{0, 80, 30};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 + 4 * i), 32'h0);
      `CHK("setting reset", 32'(model[i]), rd)
    end
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      addr = 8'(4 + 4 * (i % 3));
      val = (i < 3) ? 0 : (i < 6) ? 9999 : (i < 9) ? 10000 : int'(seed % 12000);
      running <= seed[20];
      apb(1'b1, addr, 32'(val));
      `CHK("write refused", refused(addr, val, running), er)
      if (!refused(addr, val, running)) model[i % 3] = val;
      apb(1'b0, addr, 32'h0);
      `CHK("setting readback", 32'(model[i % 3]), rd)
    end
    $display("test registers done");
    running <= 1'b0;
    apb(1'b1, `REG_CHECK_TIME, 32'(PER));
    apb(1'b1, `REG_THRESHOLD, 32'h50);
    apb(1'b1, `REG_REDUCTION, 32'(RED));
    apb(1'b1, `REG_CTRL, 32'hc);
    apb(1'b1, `REG_IRQ_ENABLE, 32'h7);
    apb(1'b1, `REG_IRQ_CLEAR, 32'h7);
    running <= 1'b1;
    seed = xs(seed);
    neg = seed[3];
    mag = 1500 + int'(seed % 1000);
    run_dev(3, 40);
    `CHK("slow shrink", exp_alarm(3), loopBreakAlarm)
    `CHK("alarm irq", 1'b1, irq)
    run_dev(8, 40);
    `CHK("fast shrink", exp_alarm(8), loopBreakAlarm)
    run_dev(0, 30);
    `CHK("stuck deviation", 1'b1, loopBreakAlarm)
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK("status word", 32'h7, rd & 32'h00000007)
    mag = 80;
    run_dev(0, 30);
    `CHK("inside threshold", 1'b0, loopBreakAlarm)
    sensorDecimals <= 2'h0;
    mag = 9;
    run_dev(0, 30);
    `CHK("whole units", 1'b1, loopBreakAlarm)
    sensorDecimals <= 2'h1;
    mag = 500;
    for (int k = 0; k < 4; k++) begin
      run_dev(0, 30);
      `CHK("alarm before hold", 1'b1, loopBreakAlarm)
      ramping <= (k == 0);
      autotuning <= (k == 1);
      manualMode <= (k == 2);
      running <= (k != 3);
      repeat (4) @(posedge clock);
      `CHK("held alarm", 1'b0, loopBreakAlarm)
      // the last pass leaves the loop stopped for the type change
      {ramping, autotuning, manualMode, running} <= {3'h0, k != 3};
    end
    apb(1'b1, `REG_CTRL, 32'h0);
    running <= 1'b1;
    run_dev(0, 30);
    `CHK("wrong type", 1'b0, loopBreakAlarm)
    running <= 1'b0;
    apb(1'b1, `REG_CTRL, 32'hc);
    apb(1'b1, `REG_CHECK_TIME, 32'h0);
    running <= 1'b1;
    run_dev(0, 30);
    `CHK("zero period", 1'b0, loopBreakAlarm)
    for (int h = 0; h < 2; h++) begin
      heatCool <= (h == 1);
      tuneCheckPeriod <= setting_type'(7 + h);
      tuneDone <= 1'b1;
      @(posedge clock);
      tuneDone <= 1'b0;
      apb(1'b0, `REG_CHECK_TIME, 32'h0);
      `CHK("tuned period", 32'h7, rd)
    end
    $display("test detection done");
    `CHK("irq pending", 1'b1, irq)
    apb(1'b1, `REG_IRQ_CLEAR, 32'h7);
    apb(1'b1, `REG_IRQ_ENABLE, 32'h0);
    `CHK("irq cleared", 1'b0, irq)
    mag = 0;
    run_dev(0, 4);
    apb(1'b1, `REG_REDUCTION, 32'h1);
    `CHK("masked irq", 1'b0, irq)
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    `CHK("reject event", 32'h4, rd)
    $display("test interrupts done");
    end_of_test();
  end
endmodule // tb_top

`default_nettype wire
